// ---- bank1_sfr_map.sv ----
// Behaviour
// (RL1) Unimplemented locations and bits read zero, ignore writes.
// (RL2) Shared registers reach one storage from both banks.
// (RL3) High latch feeds counter bits 12:8 on load.
// (RL4) Counter upper byte has no direct map path.
// (RL5) Separate power-up and other reset values.
// (RL6) Other resets are master clear and watchdog.
// (RL7) Software keeps reserved bank bits clear.
// (RL8) Unknown bits free; unchanged bits kept on resets.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "bank1_sfr_params.svh"

module bank1_sfr_map
	import bank1_sfr_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_RST,
	input wire rst_cause_e I_RST_CAUSE,
	input wire logic I_PARITY_EN,
	input wire logic [6:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	input wire logic I_PC_INC,
	input wire logic I_SLEEP,
	input wire logic I_CLRWDT,
	input wire logic [7:0] I_IND_RDATA,
	output logic [8:0] O_IND_ADDR,
	output logic O_IND_WR,
	output logic O_IND_RD,
	output logic [7:0] O_IND_WDATA,
	output logic [12:0] O_PC,
	output logic [7:0] O_STATUS,
	output logic [7:0] O_OPTION,
	output logic [5:0] O_PORT_A_DIRECTION,
	output logic [7:0] O_PORT_B_DIRECTION,
	output logic [7:0] O_INTERRUPT_CONTROL,
	output logic O_ADIE,
	output logic [1:0] O_ADC_PIN_CFG
);

	// A shared register answers in either bank, so only its low seven bits are compared.
	function automatic logic is_shared(input logic [6:0] a);
		is_shared = (a == 7'h00) || (a == 7'h02) || (a == 7'h03) ||
			(a == 7'h04) || (a == 7'h0A) || (a == 7'h0B);
	endfunction

	function automatic logic sel(input logic [7:0] full, input logic [7:0] off);
		if (is_shared(off[6:0])) begin
			sel = full[6:0] == off[6:0];
		end else begin
			sel = full == off;
		end
	endfunction

	logic [7:0] rdata_q;
	logic [7:0] status_q;
	logic [7:0] option_config_q;
	logic [7:0] indirect_pointer_q;
	logic [5:0] port_a_direction_q;
	logic [7:0] port_b_direction_q;
	logic [4:0] pc_high_latch_q;
	logic [12:0] pc_q;
	logic [7:0] interrupt_control_q;
	logic adc_int_enable_q;
	logic [1:0] adc_pin_config_q;
	logic parity_error_n_q;
	logic power_on_n_q;
	logic brown_out_n_q;
	logic [7:0] full_addr;
	logic power_up;
	logic ind_self;
	logic mapped;
	logic wr_indirect;
	logic wr_option;
	logic wr_pc_low;
	logic wr_status;
	logic wr_pointer;
	logic wr_dir_a;
	logic wr_dir_b;
	logic wr_pc_latch;
	logic wr_interrupt_control;
	logic wr_pie;
	logic wr_power;
	logic wr_adc;

	// The upper direct bank bit is ignored: software keeps it clear, so banks 2 and 3
	// never occur and the block does not decode them.
	assign full_addr = {status_q[`ST_DIRECT_BANK], I_ADDR}; // RL7

	assign power_up = (I_RST_CAUSE == RC_POWER_ON) || (I_RST_CAUSE == RC_BROWN_OUT) ||
		(I_RST_CAUSE == RC_PARITY); // RL5 RL6

	assign ind_self = indirect_pointer_q[6:0] == 7'h00;

	assign wr_indirect = I_WR && sel(full_addr, `OFF_INDIRECT_DATA); // RL2
	assign wr_option = I_WR && sel(full_addr, `OFF_OPTION_CONFIG);
	assign wr_pc_low = I_WR && sel(full_addr, `OFF_PC_LOW_BYTE); // RL2
	assign wr_status = I_WR && sel(full_addr, `OFF_STATUS_FLAGS); // RL2
	assign wr_pointer = I_WR && sel(full_addr, `OFF_INDIRECT_POINTER); // RL2
	assign wr_dir_a = I_WR && sel(full_addr, `OFF_PORT_A_DIRECTION);
	assign wr_dir_b = I_WR && sel(full_addr, `OFF_PORT_B_DIRECTION);
	assign wr_pc_latch = I_WR && sel(full_addr, `OFF_PC_HIGH_LATCH); // RL2
	assign wr_interrupt_control = I_WR && sel(full_addr, `OFF_INTERRUPT_CONTROL); // RL2
	assign wr_pie = I_WR && sel(full_addr, `OFF_PERIPH_INT_ENABLE);
	assign wr_power = I_WR && sel(full_addr, `OFF_POWER_CONTROL);
	assign wr_adc = I_WR && sel(full_addr, `OFF_ADC_PIN_CONFIG);

	assign mapped = sel(full_addr, `OFF_INDIRECT_DATA) || sel(full_addr, `OFF_OPTION_CONFIG) ||
		sel(full_addr, `OFF_PC_LOW_BYTE) || sel(full_addr, `OFF_STATUS_FLAGS) ||
		sel(full_addr, `OFF_INDIRECT_POINTER) || sel(full_addr, `OFF_PORT_A_DIRECTION) ||
		sel(full_addr, `OFF_PORT_B_DIRECTION) || sel(full_addr, `OFF_PC_HIGH_LATCH) ||
		sel(full_addr, `OFF_INTERRUPT_CONTROL) || sel(full_addr, `OFF_PERIPH_INT_ENABLE) ||
		sel(full_addr, `OFF_POWER_CONTROL) || sel(full_addr, `OFF_ADC_PIN_CONFIG);

	// The indirect port is not storage; pointing it at itself reads zero and writes nothing.
	assign O_IND_ADDR = {status_q[`ST_INDIRECT_BANK_HIGH], indirect_pointer_q};
	assign O_IND_WR = wr_indirect && !ind_self; // RL1
	assign O_IND_RD = I_RD && sel(full_addr, `OFF_INDIRECT_DATA) && !ind_self;
	assign O_IND_WDATA = I_WDATA;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rdata_q <= 8'h00;
		end else if (!I_RD) begin
			rdata_q <= 8'h00;
		end else if (sel(full_addr, `OFF_INDIRECT_DATA)) begin
			rdata_q <= ind_self ? 8'h00 : I_IND_RDATA;
		end else if (sel(full_addr, `OFF_OPTION_CONFIG)) begin
			rdata_q <= option_config_q;
		end else if (sel(full_addr, `OFF_PC_LOW_BYTE)) begin
			rdata_q <= pc_q[7:0]; // RL4
		end else if (sel(full_addr, `OFF_STATUS_FLAGS)) begin
			rdata_q <= status_q;
		end else if (sel(full_addr, `OFF_INDIRECT_POINTER)) begin
			rdata_q <= indirect_pointer_q;
		end else if (sel(full_addr, `OFF_PORT_A_DIRECTION)) begin
			rdata_q <= {2'h0, port_a_direction_q}; // RL1
		end else if (sel(full_addr, `OFF_PORT_B_DIRECTION)) begin
			rdata_q <= port_b_direction_q;
		end else if (sel(full_addr, `OFF_PC_HIGH_LATCH)) begin
			rdata_q <= {3'h0, pc_high_latch_q}; // RL1
		end else if (sel(full_addr, `OFF_INTERRUPT_CONTROL)) begin
			rdata_q <= interrupt_control_q;
		end else if (sel(full_addr, `OFF_PERIPH_INT_ENABLE)) begin
			rdata_q <= {1'h0, adc_int_enable_q, 6'h00}; // RL1
		end else if (sel(full_addr, `OFF_POWER_CONTROL)) begin
			rdata_q <= {I_PARITY_EN, 4'h0, parity_error_n_q, power_on_n_q, brown_out_n_q};
		end else if (sel(full_addr, `OFF_ADC_PIN_CONFIG)) begin
			rdata_q <= {6'h00, adc_pin_config_q}; // RL1
		end else begin
			rdata_q <= 8'h00; // RL1
		end
	end

	// Loading the low byte loads the whole counter; the upper bits only ever come
	// from the latch or from the increment carry.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pc_q <= 13'h0000;
		end else if (wr_pc_low) begin
			pc_q <= {pc_high_latch_q, I_WDATA}; // RL3 RL4
		end else if (I_PC_INC) begin
			pc_q <= pc_q + 13'h0001;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pc_high_latch_q <= `RST_PC_HIGH_LATCH; // RL5
		end else if (wr_pc_latch) begin
			pc_high_latch_q <= I_WDATA[4:0]; // RL3
		end
	end

	// The timeout and power-down flags are not writable; the arithmetic flags are
	// unknown at power-up and are cleared here for a deterministic start.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			if (power_up) begin
				status_q <= `RST_STATUS_POWER_UP; // RL5 RL8
			end else begin
				status_q[7:5] <= 3'h0; // RL5
				if (I_RST_CAUSE == RC_WATCHDOG) begin
					status_q[`ST_TIMEOUT] <= 1'b0; // RL6
				end
			end
		end else begin
			if (wr_status) begin
				status_q[7:5] <= I_WDATA[7:5];
				status_q[2:0] <= I_WDATA[2:0];
			end
			if (I_CLRWDT) begin
				status_q[`ST_TIMEOUT] <= 1'b1;
				status_q[`ST_POWER_DOWN] <= 1'b1;
			end else if (I_SLEEP) begin
				status_q[`ST_TIMEOUT] <= 1'b1;
				status_q[`ST_POWER_DOWN] <= 1'b0;
			end
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			if (power_up) begin
				indirect_pointer_q <= 8'h00; // RL8
			end
		end else if (wr_pointer) begin
			indirect_pointer_q <= I_WDATA;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			option_config_q <= `RST_OPTION_CONFIG; // RL5
			port_a_direction_q <= `RST_PORT_A_DIRECTION;
			port_b_direction_q <= `RST_PORT_B_DIRECTION;
			adc_int_enable_q <= 1'b0;
			adc_pin_config_q <= `RST_ADC_PIN_CONFIG;
		end else begin
			if (wr_option) begin
				option_config_q <= I_WDATA;
			end
			if (wr_dir_a) begin
				port_a_direction_q <= I_WDATA[5:0]; // RL1
			end
			if (wr_dir_b) begin
				port_b_direction_q <= I_WDATA;
			end
			if (wr_pie) begin
				adc_int_enable_q <= I_WDATA[`PIE_ADC]; // RL1
			end
			if (wr_adc) begin
				adc_pin_config_q <= I_WDATA[1:0]; // RL1
			end
		end
	end

	// The lowest interrupt flag is unknown at power-up and kept over other resets.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			interrupt_control_q[7:1] <= 7'h00; // RL5
			if (power_up) begin
				interrupt_control_q[0] <= 1'b0; // RL8
			end
		end else if (wr_interrupt_control) begin
			interrupt_control_q <= I_WDATA;
		end
	end

	// Cause flags are active low; the cause of a power-up reset clears its own flag.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			parity_error_n_q <= I_RST_CAUSE != RC_PARITY; // RL5
			if (power_up) begin
				power_on_n_q <= I_RST_CAUSE != RC_POWER_ON; // RL5
				brown_out_n_q <= I_RST_CAUSE != RC_BROWN_OUT;
			end
		end else if (wr_power) begin
			parity_error_n_q <= I_WDATA[`PWR_PARITY_ERROR];
			power_on_n_q <= I_WDATA[`PWR_POWER_ON];
			brown_out_n_q <= I_WDATA[`PWR_BROWN_OUT];
		end
	end

	assign O_RDATA = rdata_q;
	assign O_PC = pc_q;
	assign O_STATUS = status_q;
	assign O_OPTION = option_config_q;
	assign O_PORT_A_DIRECTION = port_a_direction_q;
	assign O_PORT_B_DIRECTION = port_b_direction_q;
	assign O_INTERRUPT_CONTROL = interrupt_control_q;
	assign O_ADIE = adc_int_enable_q;
	assign O_ADC_PIN_CFG = adc_pin_config_q;

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);

	property p_unmapped_zero;
		I_RD && !mapped |=> O_RDATA == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read not zero."); // RL1

	property p_unmapped_write;
		I_WR && !mapped |=> $stable(O_OPTION) && $stable(O_PORT_B_DIRECTION) && $stable(O_INTERRUPT_CONTROL);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write landed."); // RL1

	property p_shared_pointer;
		I_WR && I_ADDR == 7'h04 |=> indirect_pointer_q == $past(I_WDATA);
	endproperty
	a_shared_pointer: assert property (p_shared_pointer) else $error("Shared pointer missed."); // RL2

	property p_counter_load;
		wr_pc_low |=> O_PC == {$past(pc_high_latch_q), $past(I_WDATA)};
	endproperty
	a_counter_load: assert property (p_counter_load) else $error("Counter load wrong."); // RL3

	property p_high_hidden;
		$changed(O_PC[12:8]) && !$past(I_RST) |->
			$past(wr_pc_low) || ($past(I_PC_INC) && $past(O_PC[7:0]) == 8'hFF);
	endproperty
	a_high_hidden: assert property (p_high_hidden) else $error("Counter high changed alone."); // RL4

	property p_power_up_values;
		$fell(I_RST) && $past(power_up) |->
			O_STATUS == 8'h18 && O_OPTION == 8'hFF && O_PORT_A_DIRECTION == 6'h3F &&
			!power_on_n_q == ($past(I_RST_CAUSE) == RC_POWER_ON);
	endproperty
	a_power_up_values: assert property (p_power_up_values) else $error("Power-up state bad."); // RL5

	property p_watchdog_reset;
		$fell(I_RST) && $past(I_RST_CAUSE) == RC_WATCHDOG |->
			!O_STATUS[4] && O_STATUS[7:5] == 3'h0;
	endproperty
	a_watchdog_reset: assert property (p_watchdog_reset) else $error("Watchdog status bad."); // RL6

	property p_kept_pointer;
		$fell(I_RST) && !$past(power_up) && !$past(I_RST, 2) && !$past(I_WR, 2) |->
			indirect_pointer_q == $past(indirect_pointer_q, 2);
	endproperty
	a_kept_pointer: assert property (p_kept_pointer) else $error("Pointer not kept on reset."); // RL8

	property p_pie_top;
		I_RD && sel(full_addr, `OFF_PERIPH_INT_ENABLE) |=>
			O_RDATA[7] == 1'b0 && O_RDATA[5:0] == 6'h00;
	endproperty
	a_pie_top: assert property (p_pie_top) else $error("Enable spare bits not zero."); // RL1

	property p_latch_top;
		I_RD && sel(full_addr, `OFF_PC_HIGH_LATCH) |=> O_RDATA[7:5] == 3'h0;
	endproperty
	a_latch_top: assert property (p_latch_top) else $error("Latch top bits not zero."); // RL1

	c_bank0_pointer: cover property (I_WR && I_ADDR == 7'h04 && !status_q[5]);
	c_counter_load: cover property (wr_pc_low && pc_high_latch_q != 5'h00);
	c_indirect_read: cover property (O_IND_RD ##1 O_RDATA != 8'h00);
	c_watchdog_reset: cover property ($fell(I_RST) && $past(I_RST_CAUSE) == RC_WATCHDOG);
	c_indirect_write: cover property (O_IND_WR);

endmodule
`default_nettype wire

// ---- bank1_sfr_map_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module bank1_sfr_map_tb_top import bank1_sfr_pkg::*;;
	logic I_CLK = 1'b0;
	logic I_RST, I_PARITY_EN, I_WR, I_RD, I_PC_INC, I_SLEEP, I_CLRWDT;
	rst_cause_e I_RST_CAUSE;
	logic [6:0] I_ADDR;
	logic [7:0] I_WDATA, I_IND_RDATA, O_RDATA, O_IND_WDATA, O_STATUS, O_OPTION, O_PORT_B_DIRECTION, O_INTERRUPT_CONTROL;
	logic [8:0] O_IND_ADDR;
	logic O_IND_WR, O_IND_RD, O_ADIE;
	logic [12:0] O_PC;
	logic [5:0] O_PORT_A_DIRECTION;
	logic [1:0] O_ADC_PIN_CFG;
	int error_cnt = 0;
	int checked = 0;
	logic pu;
	logic [6:0] ra [7] = '{7'h01, 7'h05, 7'h06, 7'h0A, 7'h0C, 7'h1F, 7'h0E};
	logic [7:0] rv [7] = '{8'hFF, 8'h3F, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h85};
	logic [7:0] mk [7] = '{8'hFF, 8'h3F, 8'hFF, 8'h1F, 8'h40, 8'h03, 8'h87};
	logic [6:0] ua [7] = '{7'h07, 7'h08, 7'h09, 7'h0D, 7'h0F, 7'h10, 7'h1E};

	always #20 I_CLK = ~I_CLK;

	bank1_sfr_map u_bank1_sfr_map (.I_CLK(I_CLK), .I_RST(I_RST), .I_RST_CAUSE(I_RST_CAUSE),
		.I_PARITY_EN(I_PARITY_EN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
		.I_RD(I_RD), .O_RDATA(O_RDATA), .I_PC_INC(I_PC_INC), .I_SLEEP(I_SLEEP),
		.I_CLRWDT(I_CLRWDT), .I_IND_RDATA(I_IND_RDATA), .O_IND_ADDR(O_IND_ADDR),
		.O_IND_WR(O_IND_WR), .O_IND_RD(O_IND_RD), .O_IND_WDATA(O_IND_WDATA), .O_PC(O_PC),
		.O_STATUS(O_STATUS), .O_OPTION(O_OPTION), .O_PORT_A_DIRECTION(O_PORT_A_DIRECTION), .O_PORT_B_DIRECTION(O_PORT_B_DIRECTION),
		.O_INTERRUPT_CONTROL(O_INTERRUPT_CONTROL), .O_ADIE(O_ADIE), .O_ADC_PIN_CFG(O_ADC_PIN_CFG));

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_w(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Each access ends on a rising edge, so strobes never get two assignments in one step.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
		@(posedge I_CLK);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		@(negedge I_CLK);
		chk("read_data", e, O_RDATA);
		@(negedge I_CLK);
		chk("read_idle", 8'h00, O_RDATA);
		@(posedge I_CLK);
	endtask

	task automatic do_reset(input rst_cause_e c);
		I_RST_CAUSE <= c;
		I_RST <= 1'b1;
		@(posedge I_CLK);
		I_RST <= 1'b0;
		@(posedge I_CLK);
	endtask

	initial begin
		repeat (5000) @(posedge I_CLK);
		error_cnt++;
		complete_run();
	end

	initial begin
		{I_WR, I_RD, I_PC_INC, I_SLEEP, I_CLRWDT} = 5'h00;
		I_ADDR = 7'h00;
		I_WDATA = 8'h00;
		I_IND_RDATA = 8'h00;
		I_PARITY_EN = 1'b1;
		I_RST_CAUSE = RC_POWER_ON;
		I_RST = 1'b1;
		repeat (16) @(posedge I_CLK);
		I_RST <= 1'b0;
		@(posedge I_CLK);
		wr(7'h03, 8'h20);
		rd(7'h03, 8'h38);
		for (int k = 0; k < 7; k++) rd(ra[k], rv[k]);
		for (int k = 0; k < 7; k++) begin
			wr(ra[k], 8'hFF);
			rd(ra[k], mk[k]);
			wr(ua[k], 8'hFF);
			rd(ua[k], 8'h00);
		end
		@(negedge I_CLK);
		chk("port_a_direction", 8'h3F, {2'h0, O_PORT_A_DIRECTION});
		chk("adie", 8'h01, {7'h00, O_ADIE});
		chk("adc_cfg", 8'h03, {6'h00, O_ADC_PIN_CFG});
		@(posedge I_CLK);
		// Shared registers must survive a bank switch; bank-0 option is not ours.
		wr(7'h0B, 8'hA5);
		wr(7'h04, 8'h3C);
		wr(7'h03, 8'h00);
		rd(7'h0B, 8'hA5);
		rd(7'h04, 8'h3C);
		rd(7'h01, 8'h00);
		chk("interrupt_control", 8'hA5, O_INTERRUPT_CONTROL);
		wr(7'h04, 8'hC3);
		wr(7'h03, 8'h20);
		rd(7'h04, 8'hC3);
		wr(7'h0A, 8'h15);
		I_PC_INC <= 1'b1;
		I_ADDR <= 7'h02;
		I_WDATA <= 8'h34;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_PC_INC <= 1'b0;
		I_WR <= 1'b0;
		@(negedge I_CLK);
		chk_w("pc_load", 16'h1534, 16'(O_PC));
		@(posedge I_CLK);
		I_PC_INC <= 1'b1;
		@(posedge I_CLK);
		I_PC_INC <= 1'b0;
		@(posedge I_CLK);
		wr(7'h0A, 8'h0F);
		@(negedge I_CLK);
		chk_w("pc_inc", 16'h1535, 16'(O_PC));
		@(posedge I_CLK);
		rd(7'h02, 8'h35);
		rd(7'h0A, 8'h0F);
		wr(7'h04, 8'h10);
		I_ADDR <= 7'h00;
		I_IND_RDATA <= 8'hC3;
		I_RD <= 1'b1;
		@(negedge I_CLK);
		chk("ind_rd", 8'h01, {7'h00, O_IND_RD});
		chk_w("ind_addr", 16'h0010, 16'(O_IND_ADDR));
		@(posedge I_CLK);
		I_RD <= 1'b0;
		@(negedge I_CLK);
		chk("ind_data", 8'hC3, O_RDATA);
		@(posedge I_CLK);
		I_WDATA <= 8'h96;
		I_WR <= 1'b1;
		@(negedge I_CLK);
		chk("ind_wr", 8'h01, {7'h00, O_IND_WR});
		chk("ind_wdata", 8'h96, O_IND_WDATA);
		@(posedge I_CLK);
		I_WR <= 1'b0;
		@(posedge I_CLK);
		wr(7'h04, 8'h00);
		rd(7'h00, 8'h00);
		I_WR <= 1'b1;
		@(negedge I_CLK);
		chk("ind_self_wr", 8'h00, {7'h00, O_IND_WR});
		@(posedge I_CLK);
		I_WR <= 1'b0;
		@(posedge I_CLK);
		for (int i = 0; i < 5; i++) begin
			wr(7'h03, 8'h25);
			wr(7'h04, 8'h5A);
			wr(7'h06, 8'h00);
			wr(7'h01, 8'h00);
			wr(7'h0E, 8'h00);
			I_SLEEP <= 1'b1;
			I_CLRWDT <= (i == 0);
			@(posedge I_CLK);
			I_SLEEP <= 1'b0;
			I_CLRWDT <= 1'b0;
			@(negedge I_CLK);
			chk("status_flags", (i == 0) ? 8'h3D : 8'h35, O_STATUS);
			@(posedge I_CLK);
			do_reset(rst_cause_e'(i));
			pu = (i < 3);
			@(negedge I_CLK);
			chk("status_rst", pu ? 8'h18 : ((i == 4) ? 8'h05 : 8'h15), O_STATUS);
			chk("port_b_direction_rst", 8'hFF, O_PORT_B_DIRECTION);
			chk("option_rst", 8'hFF, O_OPTION);
			@(posedge I_CLK);
			rd(7'h04, pu ? 8'h00 : 8'h5A);
			wr(7'h03, 8'h20);
			rd(7'h0E, {5'h10, pu ? {i != 2, i != 0, i != 1} : 3'b100});
		end
		complete_run();
	end
endmodule
`default_nettype wire

// ---- bank1_sfr_params.svh ----
`ifndef BANK1_SFR_PARAMS_SVH
`define BANK1_SFR_PARAMS_SVH

// Bank 1 addresses, with bit 7 standing for the direct bank bit.
`define OFF_INDIRECT_DATA 8'h80
`define OFF_OPTION_CONFIG 8'h81
`define OFF_PC_LOW_BYTE 8'h82
`define OFF_STATUS_FLAGS 8'h83
`define OFF_INDIRECT_POINTER 8'h84
`define OFF_PORT_A_DIRECTION 8'h85
`define OFF_PORT_B_DIRECTION 8'h86
`define OFF_PC_HIGH_LATCH 8'h8A
`define OFF_INTERRUPT_CONTROL 8'h8B
`define OFF_PERIPH_INT_ENABLE 8'h8C
`define OFF_POWER_CONTROL 8'h8E
`define OFF_ADC_PIN_CONFIG 8'h9F

// Reset values.
`define RST_OPTION_CONFIG 8'hFF
`define RST_PORT_A_DIRECTION 6'h3F
`define RST_PORT_B_DIRECTION 8'hFF
`define RST_PC_HIGH_LATCH 5'h00
`define RST_ADC_PIN_CONFIG 2'h0
`define RST_STATUS_POWER_UP 8'h18

// Field positions.
`define ST_INDIRECT_BANK_HIGH 7
`define ST_DIRECT_BANK_UPPER 6
`define ST_DIRECT_BANK 5
`define ST_TIMEOUT 4
`define ST_POWER_DOWN 3
`define PWR_PARITY_ENABLE 7
`define PWR_PARITY_ERROR 2
`define PWR_POWER_ON 1
`define PWR_BROWN_OUT 0
`define PIE_ADC 6

`endif

// ---- bank1_sfr_pkg.sv ----
`default_nettype none
package bank1_sfr_pkg;
	typedef enum logic [2:0] {
		RC_POWER_ON,
		RC_BROWN_OUT,
		RC_PARITY,
		RC_MASTER_CLEAR,
		RC_WATCHDOG
	} rst_cause_e;
endpackage
`default_nettype wire
